// ---- shared/serial_port_defs.vh ----
// register offsets, field positions, reset values and timing counts
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_BDH         3'h0
`define OFS_BDL         3'h1
`define OFS_C1          3'h2
`define OFS_C2          3'h3
`define OFS_S1          3'h4
`define OFS_S2          3'h5
`define OFS_C3          3'h6
`define OFS_DATA        3'h7
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_BRK_IE      7
`define BIT_EDGE_IE     6
`define BIT_LOOP        7
`define BIT_WFRZ        6
`define BIT_RX_SOURCE_SELECT        5
`define BIT_NINE        4
`define BIT_WAKE        3
`define BIT_QTYPE       2
`define BIT_PEN         1
`define BIT_PODD        0
`define BIT_TIE         7
`define BIT_TX_DONE_IRQ_EN        6
`define BIT_RIE         5
`define BIT_QIE         4
`define BIT_TE          3
`define BIT_RE          2
`define BIT_STBY        1
`define BIT_SBK         0
`define BIT_BRKF        7
`define BIT_EDGEF       6
`define BIT_LBRK        2
`define BIT_TX9         6
`define BIT_SWDIR       5
// ----------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------
`define BDL_RESET       8'h04
`define DIV_ZERO        13'h0000
`define DIV_ONE         13'h0001
`define SUB_LAST        4'hF
`define SUB_MID         4'h7
`define LEN_8           4'hA
`define LEN_9           4'hB
`define BRK_8           4'hD
`define BRK_9           4'hE
`define ONE_BIT         4'h1
`endif

// ---- verilog/serial_port.v ----
// asynchronous serial port: registers, baud generator, transmitter, receiver
//
// Local design decisions: the strobed register port and the placing of the registers.
`include "serial_port_defs.vh"

//Behaviour
//- high divisor byte applies on low byte write
//- zero divisor stops; rate is clock/(16*divisor)
//- low byte resets nonzero; baud waits first enable
//- bdh bits 7,6 enable break, edge interrupts
//- loopback feeds transmitter into receiver, pin unused
//- rx source picks internal loop or single-wire
//- wait freeze bit stops port in wait
//- length bit selects eight or nine data bits
//- wake bit: idle-line or address-mark wakeup
//- idle count starts after start or stop
//- parity generated and checked on top bit
//- parity type: even when zero, odd when one
//- c2 bits 7..4 enable the four flag interrupts
//- tx enable owns pin until activity finishes
//- toggling tx enable queues an idle character
//- single-wire direction bit drives or receives line
//- rx pin freed when disabled or looping
//- standby cleared by idle or address mark
//- break bit queues breaks while it stays set
//- status one read-only, cleared by sequences
//- tx empty clears after status read, data write
//- break and edge flags clear by writing one
//- long break gives 13 or 14 bit times
module serial_port (
    // clock and reset
    input  wire       clock,
    input  wire       srst,
    // register port
    input  wire [2:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    // processor state
    input  wire       wait_mode,
    // serial pins
    output reg        txd_out,
    output reg        txd_oe,
    input  wire       txd_in,
    input  wire       rxd_in,
    output reg        rxd_used,
    // interrupt request
    output reg        irq
);
// ----------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------
function parity_of;
    input [8:0] d;
    input       nine;
    input       odd;
    begin
        parity_of = (nine ? ^d[7:0] : ^d[6:0]) ^ odd;
    end
endfunction

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
reg [7:0]  bdh_r;
reg [4:0]  div_hi_r;
reg [7:0]  bdl_r;
reg [7:0]  c1_r;
reg [7:0]  c2_r;
reg        lbrk_r;
reg        tx9_r;
reg        swdir_r;
reg [7:0]  txbuf_r;
reg        tx_empty_flag_r, tc_r, rx_full_flag_r, quiet_r, ovr_r, fe_r, pf_r;
reg        brkf_r, edgef_r;
reg        tx_arm_r, rx_arm_r;
reg        started_r;
reg [12:0] brc_r;
reg        tx_busy_r, pend_idle_r, pend_brk_r, brk_run_r;
reg [13:0] tx_sh_r;
reg [3:0]  tx_cnt_r, tx_sub_r;
reg        rx_busy_r;
reg [10:0] rx_sh_r;
reg [3:0]  rx_cnt_r, rx_sub_r;
reg [8:0]  rxd_r;
reg        rx_prev_r;
reg [7:0]  high_cnt_r;
reg        quiet_arm_r;

wire [12:0] divisor = {div_hi_r, bdl_r};
wire nine  = c1_r[`BIT_NINE];
wire loop  = c1_r[`BIT_LOOP];
wire te    = c2_r[`BIT_TE];
wire re    = c2_r[`BIT_RE];
wire stby  = c2_r[`BIT_STBY];
wire break_queue   = c2_r[`BIT_SBK];
wire frz   = c1_r[`BIT_WFRZ] & wait_mode;
wire wr_c2   = wr & (addr == `OFS_C2);
wire wr_data = wr & (addr == `OFS_DATA);
wire rd_s1   = rd & (addr == `OFS_S1);
wire rd_data = rd & (addr == `OFS_DATA);
wire [3:0] frame_len = nine ? `LEN_9 : `LEN_8;
wire [3:0] brk_len = lbrk_r ? (nine ? `BRK_9 : `BRK_8)
                            : frame_len;

// ----------------------------------------------------------------------
// baud generator
// ----------------------------------------------------------------------
// zero divisor gives no tick; the counter alternates between zero and its top value every cycle
wire tick = started_r & (divisor != `DIV_ZERO) & ~frz
            & (brc_r <= `DIV_ONE);

always @(posedge clock) begin
    if (srst) begin
        brc_r     <= `DIV_ZERO;
        started_r <= 1'b0;
    end else begin
        if (wr_c2 & (wdata[`BIT_TE] | wdata[`BIT_RE]))
            started_r <= 1'b1;
        if (~started_r | frz)
            brc_r <= brc_r;
        else if (tick | (brc_r > divisor))
            brc_r <= divisor;
        else
            brc_r <= brc_r - `DIV_ONE;
    end
end

// ----------------------------------------------------------------------
// transmitter
// ----------------------------------------------------------------------
wire [8:0] tx_word = {tx9_r, txbuf_r};
wire       tx_par  = parity_of(tx_word, nine, c1_r[`BIT_PODD]);
wire [8:0] tx_data = ~c1_r[`BIT_PEN] ? tx_word :
                     nine ? {tx_par, tx_word[7:0]}
                          : {1'b0, tx_par, tx_word[6:0]};
wire bit_end  = tick & (tx_sub_r == `SUB_LAST);
wire tx_done  = tx_busy_r & bit_end & (tx_cnt_r == `ONE_BIT);
wire tx_free  = (~tx_busy_r & tick) | tx_done;
wire go_idle  = tx_free & pend_idle_r;
wire go_brk   = tx_free & ~pend_idle_r & pend_brk_r;
wire go_data  = tx_free & ~pend_idle_r & ~pend_brk_r & (te | txd_oe) & ~tx_empty_flag_r;
wire te_rise  = wr_c2 & wdata[`BIT_TE] & ~te;
wire sbk_rise = wr_c2 & wdata[`BIT_SBK] & ~break_queue;
wire tx_pend  = pend_idle_r | pend_brk_r | ~tx_empty_flag_r;
wire sw_mode  = loop & c1_r[`BIT_RX_SOURCE_SELECT];
wire tx_line  = tx_busy_r ? tx_sh_r[0] : 1'b1;

always @(posedge clock) begin
    if (srst) begin
        tx_busy_r   <= 1'b0;
        tx_sh_r     <= {14{1'b1}};
        tx_cnt_r    <= 4'h0;
        tx_sub_r    <= 4'h0;
        pend_idle_r <= 1'b0;
        pend_brk_r  <= 1'b0;
        brk_run_r   <= 1'b0;
    end else begin
        if (tx_busy_r & tick)
            tx_sub_r <= tx_sub_r + 4'h1;
        if (tx_busy_r & bit_end) begin
            tx_sh_r  <= {1'b1, tx_sh_r[13:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
        end
        if (tx_done)
            tx_busy_r <= 1'b0;
        if (te_rise)
            pend_idle_r <= 1'b1;
        else if (go_idle)
            pend_idle_r <= 1'b0;
        // a break finishing with the bit still set queues another
        if (sbk_rise | (tx_done & brk_run_r & break_queue))
            pend_brk_r <= 1'b1;
        else if (go_brk)
            pend_brk_r <= 1'b0;
        if (go_idle | go_brk | go_data) begin
            tx_busy_r <= 1'b1;
            tx_sub_r  <= 4'h0;
            brk_run_r <= go_brk;
        end
        if (go_idle) begin
            tx_sh_r  <= {14{1'b1}};
            tx_cnt_r <= frame_len;
        end
        if (go_brk) begin
            tx_sh_r  <= 14'h0000;
            tx_cnt_r <= brk_len;
        end
        if (go_data) begin
            tx_sh_r  <= nine ? {4'hF, tx_data, 1'b0}
                             : {5'h1F, tx_data[7:0], 1'b0};
            tx_cnt_r <= frame_len;
        end
    end
end

// ----------------------------------------------------------------------
// pin routing
// ----------------------------------------------------------------------
// loop mode reads the transmitter; single-wire reads the shared line
wire rx_src = ~loop ? rxd_in :
              (c1_r[`BIT_RX_SOURCE_SELECT] ? txd_in : tx_line);

always @(posedge clock) begin
    if (srst) begin
        txd_out  <= 1'b1;
        txd_oe   <= 1'b0;
        rxd_used <= 1'b0;
    end else begin
        txd_out  <= tx_line;
        txd_oe   <= (te | tx_busy_r | pend_idle_r | pend_brk_r)
                    & ~(sw_mode & ~swdir_r);
        rxd_used <= re & ~loop;
    end
end

// ----------------------------------------------------------------------
// receiver
// ----------------------------------------------------------------------
wire samp    = rx_busy_r & tick & (rx_sub_r == `SUB_MID);
wire rx_last = samp & (rx_cnt_r == `ONE_BIT);
wire [10:0] rx_fr = {rx_src, rx_sh_r[10:1]};
wire [8:0]  rx_dat = nine ? rx_fr[9:1] : {1'b0, rx_fr[9:2]};
wire rx_msb  = nine ? rx_dat[8] : rx_dat[7];
wire rx_perr = c1_r[`BIT_PEN] &
               (parity_of(rx_dat, nine, c1_r[`BIT_PODD]) != rx_msb);
wire addr_wake = stby & c1_r[`BIT_WAKE] & rx_msb;
wire take    = rx_last & (~stby | addr_wake);
wire quiet_hit = re & ~rx_busy_r & tick &
                 (high_cnt_r == {frame_len - `ONE_BIT, `SUB_LAST});
wire idle_wake = quiet_hit & stby & ~c1_r[`BIT_WAKE];
wire brk_seen  = rx_last & (rx_dat == 9'h000) & ~rx_src;

always @(posedge clock) begin
    if (srst) begin
        rx_busy_r   <= 1'b0;
        rx_sh_r     <= 11'h000;
        rx_cnt_r    <= 4'h0;
        rx_sub_r    <= 4'h0;
        rxd_r       <= 9'h000;
        rx_prev_r   <= 1'b1;
        high_cnt_r  <= 8'h00;
        quiet_arm_r <= 1'b0;
    end else begin
        rx_prev_r <= rx_src;
        if (~re) begin
            rx_busy_r <= 1'b0;
        end else if (~rx_busy_r & tick & ~rx_src) begin
            rx_busy_r <= 1'b1;
            rx_sub_r  <= 4'h0;
            rx_cnt_r  <= frame_len;
        end else if (rx_busy_r & tick) begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (samp) begin
                rx_sh_r  <= rx_fr;
                rx_cnt_r <= rx_cnt_r - 4'h1;
                if (rx_last | ((rx_cnt_r == frame_len) & rx_src))
                    rx_busy_r <= 1'b0;
            end
        end
        if (take & ~rx_full_flag_r)
            rxd_r <= rx_dat;
        // high time counts in ticks; the quiet-type bit decides if
        // the ones inside a frame count or only those after the stop
        if (~rx_src | (rx_busy_r & c1_r[`BIT_QTYPE]))
            high_cnt_r <= 8'h00;
        else if (tick & (high_cnt_r != {frame_len - `ONE_BIT, `SUB_LAST}))
            high_cnt_r <= high_cnt_r + 8'h01;
        if (take)
            quiet_arm_r <= 1'b1;
        else if (quiet_hit)
            quiet_arm_r <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// control registers
// ----------------------------------------------------------------------
always @(posedge clock) begin
    if (srst) begin
        bdh_r    <= 8'h00;
        div_hi_r <= 5'h00;
        bdl_r    <= `BDL_RESET;
        c1_r     <= 8'h00;
        c2_r     <= 8'h00;
        lbrk_r   <= 1'b0;
        tx9_r    <= 1'b0;
        swdir_r  <= 1'b0;
        txbuf_r  <= 8'h00;
    end else begin
        if (wr & (addr == `OFS_BDH))
            bdh_r <= wdata;
        if (wr & (addr == `OFS_BDL)) begin
            bdl_r    <= wdata;
            div_hi_r <= bdh_r[4:0];
        end
        if (wr & (addr == `OFS_C1))
            c1_r <= wdata;
        if (wr_c2)
            c2_r <= wdata;
        else if (idle_wake | (rx_last & addr_wake))
            c2_r[`BIT_STBY] <= 1'b0;
        if (wr & (addr == `OFS_S2))
            lbrk_r <= wdata[`BIT_LBRK];
        if (wr & (addr == `OFS_C3)) begin
            tx9_r   <= wdata[`BIT_TX9];
            swdir_r <= wdata[`BIT_SWDIR];
        end
        if (wr_data)
            txbuf_r <= wdata;
    end
end

// ----------------------------------------------------------------------
// status flags: a hardware set wins over a software clear
// ----------------------------------------------------------------------
wire tc_clr = tc_r & tx_arm_r & (wr_data | te_rise | sbk_rise);
wire w1c    = wr & (addr == `OFS_S2);

always @(posedge clock) begin
    if (srst) begin
        tx_empty_flag_r   <= 1'b1;
        tc_r     <= 1'b1;
        rx_full_flag_r   <= 1'b0;
        quiet_r  <= 1'b0;
        ovr_r    <= 1'b0;
        fe_r     <= 1'b0;
        pf_r     <= 1'b0;
        brkf_r   <= 1'b0;
        edgef_r  <= 1'b0;
        tx_arm_r <= 1'b0;
        rx_arm_r <= 1'b0;
    end else begin
        // the write to status one itself has no effect
        if (rd_s1)
            tx_arm_r <= tx_empty_flag_r | tc_r;
        else if (wr_data)
            tx_arm_r <= 1'b0;
        if (rd_s1)
            rx_arm_r <= rx_full_flag_r | quiet_r | ovr_r;
        else if (rd_data)
            rx_arm_r <= 1'b0;
        if (go_data)
            tx_empty_flag_r <= 1'b1;
        else if (wr_data & tx_arm_r & tx_empty_flag_r)
            tx_empty_flag_r <= 1'b0;
        if (tx_free & ~tx_pend & ~go_data & ~(te_rise | sbk_rise))
            tc_r <= 1'b1;
        else if (tc_clr | go_brk | go_idle)
            tc_r <= 1'b0;
        if (take & ~rx_full_flag_r) begin
            rx_full_flag_r <= 1'b1;
            fe_r   <= ~rx_src;
            pf_r   <= rx_perr;
        end else if (rd_data & rx_arm_r) begin
            rx_full_flag_r <= 1'b0;
            fe_r   <= 1'b0;
            pf_r   <= 1'b0;
        end
        if (take & rx_full_flag_r)
            ovr_r <= 1'b1;
        else if (rd_data & rx_arm_r)
            ovr_r <= 1'b0;
        if (quiet_hit & quiet_arm_r & ~stby)
            quiet_r <= 1'b1;
        else if (rd_data & rx_arm_r)
            quiet_r <= 1'b0;
        if (brk_seen)
            brkf_r <= 1'b1;
        else if (w1c & wdata[`BIT_BRKF])
            brkf_r <= 1'b0;
        if (re & rx_prev_r & ~rx_src)
            edgef_r <= 1'b1;
        else if (w1c & wdata[`BIT_EDGEF])
            edgef_r <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// read port and interrupt request
// ----------------------------------------------------------------------
always @(posedge clock) begin
    if (srst) begin
        rdata <= 8'h00;
        irq   <= 1'b0;
    end else begin
        irq <= (bdh_r[`BIT_BRK_IE] & brkf_r) |
               (bdh_r[`BIT_EDGE_IE] & edgef_r) |
               (c2_r[`BIT_TIE] & tx_empty_flag_r) |
               (c2_r[`BIT_TX_DONE_IRQ_EN] & tc_r) |
               (c2_r[`BIT_RIE] & rx_full_flag_r) |
               (c2_r[`BIT_QIE] & quiet_r);
        if (rd) begin
            case (addr)
                `OFS_BDH:  rdata <= {bdh_r[7:6], 1'b0, bdh_r[4:0]};
                `OFS_BDL:  rdata <= bdl_r;
                `OFS_C1:   rdata <= c1_r;
                `OFS_C2:   rdata <= c2_r;
                `OFS_S1:   rdata <= {tx_empty_flag_r, tc_r, rx_full_flag_r, quiet_r,
                                     ovr_r, 1'b0, fe_r, pf_r};
                `OFS_S2:   rdata <= {brkf_r, edgef_r, 3'h0, lbrk_r,
                                     1'b0, rx_busy_r};
                `OFS_C3:   rdata <= {rxd_r[8], tx9_r, swdir_r, 5'h00};
                `OFS_DATA: rdata <= rxd_r[7:0];
                default:   rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
end

endmodule

// ---- verif/serial_port_checker.sv ----
// assertion checker watching the serial port's ports
`include "serial_port_defs.vh"
module serial_port_checker (
    // clock and reset
    input wire       clock,
    input wire       srst,
    // register port
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    // processor state, pins and request
    input wire       wait_mode,
    input wire       txd_out,
    input wire       txd_oe,
    input wire       txd_in,
    input wire       rxd_in,
    input wire       rxd_used,
    input wire       irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // register shadows rebuilt from bus writes
    // ------------------------------------------------------------------
    logic [7:0]  bdh_s;
    logic [7:0]  c1_s;
    logic [7:0]  c2_s;
    logic [12:0] div_s;
    logic        tx_empty_flag_k;
    logic [9:0]  low_cnt;
    wire         frz  = c1_s[`BIT_WFRZ] & wait_mode;
    wire         free = c1_s[`BIT_LOOP] | ~c2_s[`BIT_RE];
    wire         wsel = wr & ~srst;
    always @(posedge clock) begin
        if (srst) begin
            bdh_s  <= 8'h00;
            c1_s   <= 8'h00;
            c2_s   <= 8'h00;
            div_s  <= {5'h00, `BDL_RESET};
            tx_empty_flag_k <= 1'b1;
        end else if (wsel) begin
            if (addr == `OFS_BDH) bdh_s <= wdata;
            if (addr == `OFS_BDL) div_s <= {bdh_s[4:0], wdata};
            if (addr == `OFS_C1) c1_s <= wdata;
            if (addr == `OFS_C2) c2_s <= wdata;
            if (addr == `OFS_DATA) tx_empty_flag_k <= 1'b0;
        end
    end
    // frozen cycles are left out so a low run stays a whole bit count
    always @(posedge clock) begin
        if (srst || txd_out) low_cnt <= 10'h000;
        else if (!frz) low_cnt <= low_cnt + 10'h001;
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_pin_free; free [*3]; endsequence
    sequence s_frozen; frz [*3]; endsequence
    sequence s_no_div; (div_s == 13'h0000) [*3]; endsequence
    sequence s_quiet; (c2_s[7:4] == 4'h0 && bdh_s[7:6] == 2'h0) [*3];
    endsequence
    sequence s_tie_pend; (c2_s[`BIT_TIE] && tx_empty_flag_k) [*3]; endsequence
    a_reset_quiet: assert property ($fell(srst) |->
        (!txd_oe && txd_out && !irq && rdata == 8'h00))
        else $error("outputs not idle after reset");
    a_rdata_zero: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
    a_pin_free: assert property (s_pin_free |-> !rxd_used)
        else $error("receive pin held while free");
    a_tx_own: assert property ($rose(c2_s[`BIT_TE]) |-> ##[1:3] txd_oe)
        else $error("transmit pin not taken on enable");
    a_zero_div: assert property (s_no_div |-> $stable(txd_out))
        else $error("line moved with zero divisor");
    a_freeze_wait: assert property (s_frozen |-> $stable(txd_out))
        else $error("line moved while frozen");
    a_low_width: assert property ($rose(txd_out) && txd_oe |->
        low_cnt[3:0] == 4'h0 && low_cnt != 10'h000)
        else $error("low run not a whole number of bits");
    a_edge_irq: assert property (bdh_s[`BIT_EDGE_IE] && c2_s[`BIT_RE] &&
        !c1_s[`BIT_LOOP] && $fell(rxd_in) |-> ##[1:6] irq)
        else $error("edge interrupt missing");
    a_irq_quiet: assert property (s_quiet |-> !irq)
        else $error("request with all enables clear");
    a_tie_irq: assert property (s_tie_pend |-> irq)
        else $error("transmit empty request missing");
endmodule

bind serial_port serial_port_checker i_serial_port_checker (
    .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .wait_mode(wait_mode), .txd_out(txd_out),
    .txd_oe(txd_oe), .txd_in(txd_in), .rxd_in(rxd_in),
    .rxd_used(rxd_used), .irq(irq));

// ---- verif/serial_partner.sv ----
// remote serial device model: sends and receives asynchronous frames
module serial_partner (
    // clock
    input  wire  clock,
    // serial lines
    input  wire  tx_line,
    output logic rx_line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx_line = 1'b1;
    // start low, data lsb first, stop high; idle stays at mark
    task automatic send(input logic [9:0] bits, input int n, input int blen);
        @(posedge clock);
        rx_line <= 1'b0;
        repeat (blen) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            rx_line <= bits[i];
            repeat (blen) @(posedge clock);
        end
        rx_line <= 1'b1;
        repeat (blen) @(posedge clock);
    endtask
    // samples mid-bit, so a wrong bit length shows up as wrong data
    task automatic recv(input int n, input int blen, output logic [9:0] bits,
                        output logic ok);
        int t;
        bits = 10'h000;
        ok = 1'b0;
        t = 0;
        while (tx_line !== 1'b0 && t < 3000) begin
            @(posedge clock);
            t++;
        end
        if (t >= 3000) return;
        repeat (blen / 2) @(posedge clock);
        if (tx_line !== 1'b0) return;
        for (int i = 0; i < n; i++) begin
            repeat (blen) @(posedge clock);
            bits[i] = tx_line;
        end
        repeat (blen) @(posedge clock);
        ok = (tx_line === 1'b1);
    endtask
endmodule

// ---- verif/serial_port_tb_top.sv ----
// self-checking testbench for the serial port
`include "serial_port_defs.vh"
module serial_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock, srst, wr, rd, wait_mode, ok;
    logic       txd_out, txd_oe, rxd_used, irq, rx_line;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, v;
    logic [9:0] bits;
    int         err_count, checks_done, cnt, ex;
    logic [7:0] rst_v [0:5] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'hC0, 8'h00};
    // transmit pin has a pull-up when the port lets go of it
    wire        tx_pin = txd_oe ? txd_out : 1'b1;
    serial_port i_serial_port (.clock(clock), .srst(srst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .wait_mode(wait_mode), .txd_out(txd_out), .txd_oe(txd_oe),
        .txd_in(tx_pin), .rxd_in(rx_line), .rxd_used(rxd_used), .irq(irq));
    serial_partner i_serial_partner (.clock(clock), .tx_line(tx_pin),
        .rx_line(rx_line));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ------------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------------
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        chk(10'(d), 10'(e));
    endtask
    task automatic pin_chk(ref logic got, input logic e);
        repeat (2) @(posedge clock);
        #1 chk(10'(got), 10'(e));
    endtask
    task automatic timeout_hit();
        err_count++;
        $display("mismatch at %0t: wait ran out", $time);
        report_and_stop();
    endtask
    task automatic wait_rx(output logic [7:0] s);
        int t;
        t = 0;
        s = 8'h00;
        while (s[5] !== 1'b1 && t < 300) begin
            rd_reg(`OFS_S1, s);
            t++;
        end
        if (t >= 300) timeout_hit();
    endtask
    task automatic tx_byte(input logic [7:0] d);
        logic [7:0] s;
        rd_reg(`OFS_S1, s);
        wr_reg(`OFS_DATA, d);
    endtask
    task automatic measure_low(output int c);
        int t;
        c = 0;
        t = 0;
        while (tx_pin !== 1'b0 && t < 600) begin
            @(posedge clock);
            t++;
        end
        if (t >= 600) return;
        while (tx_pin === 1'b0 && c < 1000) begin
            @(posedge clock);
            c++;
        end
        if (c >= 1000) timeout_hit();
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        srst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wait_mode = 1'b0;
        err_count = 0;
        checks_done = 0;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(3'(i), rst_v[i]);
        wr_reg(`OFS_S1, 8'hFF);
        rd_chk(`OFS_S1, 8'hC0);
        wr_reg(`OFS_C2, 8'h80);
        pin_chk(irq, 1'b1);
        wr_reg(`OFS_C2, 8'h00);
        $display("test reset done");
        wr_reg(`OFS_BDL, 8'h01);
        wr_reg(`OFS_BDH, 8'h01);
        wr_reg(`OFS_C2, 8'h08);
        tx_byte(8'hA5);
        i_serial_partner.recv(8, 16, bits, ok);
        chk({ok, bits[8:0]}, 10'h2A5);
        wr_reg(`OFS_BDH, 8'h00);
        wr_reg(`OFS_BDL, 8'h02);
        tx_byte(8'h3C);
        wr_reg(`OFS_C2, 8'h00);
        #1 chk(10'(txd_oe), 10'h001);
        i_serial_partner.recv(8, 32, bits, ok);
        chk({ok, bits[8:0]}, 10'h23C);
        pin_chk(txd_oe, 1'b1);
        repeat (40) @(posedge clock);
        #1 chk(10'(txd_oe), 10'h000);
        wr_reg(`OFS_BDL, 8'h01);
        wr_reg(`OFS_C2, 8'h08);
        for (int p = 0; p < 2; p++) begin
            wr_reg(`OFS_C1, 8'h12 | 8'(p));
            tx_byte(8'h03);
            i_serial_partner.recv(9, 16, bits, ok);
            chk({ok, bits[8:0]}, {1'b1, (^8'h03) ^ 1'(p), 8'h03});
        end
        $display("test transmit done");
        wr_reg(`OFS_C1, 8'h02);
        wr_reg(`OFS_C2, 8'h0C);
        pin_chk(rxd_used, 1'b1);
        i_serial_partner.send(10'h081, 8, 16);
        wait_rx(v);
        chk(10'(v & 8'h21), 10'h020);
        rd_chk(`OFS_DATA, 8'h81);
        i_serial_partner.send(10'h001, 8, 16);
        wait_rx(v);
        chk(10'(v & 8'h21), 10'h021);
        rd_reg(`OFS_DATA, v);
        wr_reg(`OFS_BDH, 8'h40);
        wr_reg(`OFS_S2, 8'h40);
        i_serial_partner.send(10'h0FF, 8, 16);
        pin_chk(irq, 1'b1);
        wr_reg(`OFS_S2, 8'h40);
        rd_reg(`OFS_S2, v);
        chk(10'(v & 8'h40), 10'h000);
        pin_chk(irq, 1'b0);
        wait_rx(v);
        rd_reg(`OFS_DATA, v);
        wr_reg(`OFS_BDH, 8'h00);
        wr_reg(`OFS_BDL, 8'h01);
        $display("test receive done");
        wr_reg(`OFS_C1, 8'h80);
        pin_chk(rxd_used, 1'b0);
        tx_byte(8'h5A);
        wait_rx(v);
        rd_chk(`OFS_DATA, 8'h5A);
        repeat (40) @(posedge clock);
        for (int b = 0; b < 2; b++) begin
            wr_reg(`OFS_C2, (8'h80 >> b) | 8'h0C);
            pin_chk(irq, 1'b1);
            wr_reg(`OFS_C2, 8'h0C);
            pin_chk(irq, 1'b0);
        end
        $display("test loop and requests done");
        for (int i = 0; i < 3; i++) begin
            wr_reg(`OFS_S2, (i == 1) ? 8'h04 : 8'h00);
            wr_reg(`OFS_C1, (i == 2) ? 8'h40 : 8'h00);
            ex = ((i == 1) ? 13 : 10) * 16 + ((i == 2) ? 100 : 0);
            fork
                measure_low(cnt);
                begin
                    wr_reg(`OFS_C2, 8'h09);
                    wr_reg(`OFS_C2, 8'h08);
                    if (i == 2) begin
                        repeat (40) @(posedge clock);
                        wait_mode <= 1'b1;
                        repeat (100) @(posedge clock);
                        wait_mode <= 1'b0;
                    end
                end
            join
            chk(10'(cnt >= ex - 2 && cnt <= ex + 2), 10'h001);
        end
        wr_reg(`OFS_C1, 8'h00);
        $display("test break done");
        wr_reg(`OFS_BDL, 8'h00);
        tx_byte(8'h00);
        measure_low(cnt);
        chk(10'(cnt), 10'h000);
        $display("test zero divisor done");
        report_and_stop();
    end
endmodule
